/* File: pkg/sysint_pkg.sv */
// Package with register map, field layout and timing constants.
package sysint_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [3:0] ADDR_RESET_SOURCE = 4'h1;
    localparam logic [3:0] ADDR_BREAK_FLAG = 4'h3;
    localparam logic [3:0] ADDR_CONTROL = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h5;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
    localparam logic [3:0] ADDR_STATE = 4'h7;

    // ---------------------------------------------------------------
    // Reset source field positions
    // ---------------------------------------------------------------
    localparam int BIT_LOW_VOLTAGE = 1;
    localparam int BIT_MONITOR = 2;
    localparam int BIT_ILLEGAL_ADDR = 3;
    localparam int BIT_ILLEGAL_OP = 4;
    localparam int BIT_WATCHDOG = 5;
    localparam int BIT_PIN = 6;

    // Control register bits.
    localparam int BIT_SHORT_STOP = 0;
    localparam int BIT_INTERNAL_OSC_CLOCK_DIS = 1;
    localparam int BIT_OSC_EN = 2;

    // Interrupt status bits.
    localparam int IRQ_TIMEOUT_DONE = 0;
    localparam int IRQ_STOP_ENTER = 1;
    localparam int IRQ_WAIT_ENTER = 2;

    localparam logic [7:0] CONTROL_RESET = 8'h04;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int POR_TIMEOUT_CYCLES = 4096;
    localparam int STOP_LONG_CYCLES = 4096;
    localparam int STOP_SHORT_CYCLES = 32;
    localparam int BUS_DIVIDE = 4;

    // Top-level phase of the clock gate.
    typedef enum logic [1:0] {
        PH_POR = 2'b00,
        PH_RUN = 2'b01,
        PH_STOP = 2'b10,
        PH_DELAY = 2'b11
    } phase_type;

    // Reset cause inputs travel together.
    typedef struct packed {
        logic power_on;
        logic low_voltage;
        logic pin;
        logic watchdog;
        logic illegal_op;
        logic illegal_addr;
        logic monitor;
    } reset_cause_type;

    // Whole state of the block.
    typedef struct packed {
        phase_type phase;
        logic [12:0] count;
        logic [1:0] div;
        logic [7:0] reset_source_status;
        logic break_clear_enable;
        logic [7:0] ctrl;
        logic [7:0] irq_st;
        logic [7:0] irq_mask;
        logic [7:0] rdata;
        logic bus_tick;
        logic rst_pin_low;
    } state_type;

endpackage

/* File: src/sim_clock_reset_status.sv */
// Clock gating, bus divider and reset-source status for the system unit.
//
// Overview of operation
// - Bus clock is oscillator divided by four.
// - Hold clocks 4096 cycles after power-on.
// - Drive reset pin low during timeout.
// - Bus clocks start when timeout completes.
// - Stop exit waits on delay counter.
// - Stop delay selectable 4096 or 32.
// - Wait stops CPU, peripherals keep clocks.
// - Pin flag marks external pin reset.
// - Watchdog flag marks watchdog reset.
// - Illegal opcode flag marks opcode reset.
// - Illegal address flag on fetches only.
// - Monitor flag marks monitor entry reset.
// - Low voltage flag marks inhibit reset.
// - Power-on or read clears all flags.
// - In break, clear only when enabled.
// - Drive oscillator enable output.
// - Oscillator clock used undivided.
// - Stop disables oscillator if configured.
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module sim_clock_reset_status (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Reset causes and mode requests.
    input wire sysint_pkg::reset_cause_type cause_in,
    input wire logic illegal_is_fetch_in,
    input wire logic stop_req_in,
    input wire logic wait_req_in,
    input wire logic wake_in,
    input wire logic break_in,
    // Register port.
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // Clock enables and pins.
    output logic bus_tick_out,
    output logic cpu_clk_en_out,
    output logic periph_clk_en_out,
    output logic reset_pin_low_out,
    output logic oscillator_enable_out,
    output logic irq_out
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    sysint_pkg::state_type q;
    sysint_pkg::state_type d;
    logic [12:0] term;
    logic clear_ok;
    logic running;
    logic [7:0] events;
    logic [7:0] causes;

    // Terminal count of the active timeout minus one.
    always_comb begin
        if (q.phase == sysint_pkg::PH_DELAY &&
            q.ctrl[sysint_pkg::BIT_SHORT_STOP]) begin
            term = 13'(sysint_pkg::STOP_SHORT_CYCLES - 1);
        end else if (q.phase == sysint_pkg::PH_DELAY) begin
            term = 13'(sysint_pkg::STOP_LONG_CYCLES - 1);
        end else begin
            term = 13'(sysint_pkg::POR_TIMEOUT_CYCLES - 1);
        end
    end

    // Flags may be cleared only outside break or with enable set.
    assign clear_ok = !break_in || q.break_clear_enable;
    assign running = q.phase == sysint_pkg::PH_RUN;

    // Cause flags gathered at bit positions.
    always_comb begin
        causes = sysint_pkg::ZERO_BYTE;
        causes[sysint_pkg::BIT_PIN] = cause_in.pin;
        causes[sysint_pkg::BIT_WATCHDOG] = cause_in.watchdog;
        causes[sysint_pkg::BIT_ILLEGAL_OP] = cause_in.illegal_op;
        // Data accesses to bad addresses never flag here.
        causes[sysint_pkg::BIT_ILLEGAL_ADDR] =
            cause_in.illegal_addr && illegal_is_fetch_in;
        causes[sysint_pkg::BIT_MONITOR] = cause_in.monitor;
        causes[sysint_pkg::BIT_LOW_VOLTAGE] = cause_in.low_voltage;
    end

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        d = q;
        events = sysint_pkg::ZERO_BYTE;
        d.bus_tick = 1'b0;
        d.rdata = sysint_pkg::ZERO_BYTE;
        case (q.phase)
            sysint_pkg::PH_POR, sysint_pkg::PH_DELAY: begin
                // Counter runs on the raw oscillator clock.
                d.count = q.count + 13'h0001;
                d.div = 2'h0;
                if (q.count == term) begin
                    d.phase = sysint_pkg::PH_RUN;
                    d.count = 13'h0000;
                    events[sysint_pkg::IRQ_TIMEOUT_DONE] = 1'b1;
                end
            end
            sysint_pkg::PH_RUN: begin
                // Divide by four for the bus tick.
                d.div = q.div + 2'h1;
                d.bus_tick = q.div == 2'(sysint_pkg::BUS_DIVIDE - 1);
                if (stop_req_in) begin
                    d.phase = sysint_pkg::PH_STOP;
                    events[sysint_pkg::IRQ_STOP_ENTER] = 1'b1;
                end
                if (wait_req_in) begin
                    events[sysint_pkg::IRQ_WAIT_ENTER] = 1'b1;
                end
            end
            sysint_pkg::PH_STOP: begin
                if (wake_in || break_in) begin
                    d.phase = sysint_pkg::PH_DELAY;
                    d.count = 13'h0000;
                end
            end
            default: begin
                d.phase = sysint_pkg::PH_POR;
            end
        endcase

        // Register reads; reading the source register clears it when clear_ok allows.
        if (rd_in) begin
            case (addr_in)
                sysint_pkg::ADDR_RESET_SOURCE: begin
                    d.rdata = q.reset_source_status;
                    if (clear_ok) begin
                        d.reset_source_status = sysint_pkg::ZERO_BYTE;
                    end
                end
                sysint_pkg::ADDR_BREAK_FLAG: d.rdata = {q.break_clear_enable, 7'h00};
                sysint_pkg::ADDR_CONTROL: d.rdata = q.ctrl;
                sysint_pkg::ADDR_IRQ_STATUS: d.rdata = q.irq_st;
                sysint_pkg::ADDR_IRQ_MASK: d.rdata = q.irq_mask;
                sysint_pkg::ADDR_STATE: d.rdata = {6'h00, q.phase};
                default: d.rdata = sysint_pkg::ZERO_BYTE;
            endcase
        end

        // Register writes.
        if (wr_in) begin
            case (addr_in)
                sysint_pkg::ADDR_BREAK_FLAG: d.break_clear_enable = wdata_in[7];
                sysint_pkg::ADDR_CONTROL: d.ctrl = wdata_in;
                sysint_pkg::ADDR_IRQ_STATUS: begin
                    if (clear_ok) begin
                        d.irq_st = q.irq_st & ~wdata_in;
                    end
                end
                sysint_pkg::ADDR_IRQ_MASK: d.irq_mask = wdata_in;
                default: begin
                end
            endcase
        end

        // New events win over a clear in the same cycle.
        d.irq_st = d.irq_st | events;

        // Reset pin is held low only through the power-on timeout.
        d.rst_pin_low = d.phase == sysint_pkg::PH_POR;
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    // A power-on or low-voltage cause restarts the power-on timeout.
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            q.phase <= sysint_pkg::PH_POR;
            q.count <= 13'h0000;
            q.div <= 2'h0;
            q.reset_source_status <= sysint_pkg::ZERO_BYTE;
            q.break_clear_enable <= 1'b0;
            q.ctrl <= sysint_pkg::CONTROL_RESET;
            q.irq_st <= sysint_pkg::ZERO_BYTE;
            q.irq_mask <= sysint_pkg::ZERO_BYTE;
            q.rdata <= sysint_pkg::ZERO_BYTE;
            q.bus_tick <= 1'b0;
            q.rst_pin_low <= 1'b1;
        end else if (cause_in.power_on) begin
            q <= d;
            q.phase <= sysint_pkg::PH_POR;
            q.count <= 13'h0000;
            q.reset_source_status <= sysint_pkg::ZERO_BYTE;
            q.rst_pin_low <= 1'b1;
        end else if (cause_in.low_voltage) begin
            q <= d;
            q.phase <= sysint_pkg::PH_POR;
            q.count <= 13'h0000;
            q.reset_source_status <= causes;
            q.rst_pin_low <= 1'b1;
        end else if (|causes) begin
            // Last reset wins: flags show only the latest cause.
            q <= d;
            q.reset_source_status <= causes;
        end else begin
            q <= d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign rdata_out = q.rdata;
    assign bus_tick_out = q.bus_tick;
    // CPU pauses in wait; peripherals keep running.
    assign cpu_clk_en_out = running && !wait_req_in;
    assign periph_clk_en_out = running;
    assign reset_pin_low_out = q.rst_pin_low;
    // Oscillator follows the enable bit and is off in stop when the disable bit is set.
    assign oscillator_enable_out = q.ctrl[sysint_pkg::BIT_OSC_EN] &&
        !(q.phase == sysint_pkg::PH_STOP &&
          q.ctrl[sysint_pkg::BIT_INTERNAL_OSC_CLOCK_DIS]);
    assign irq_out = |(q.irq_st & q.irq_mask);

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    // The pin stays low for the whole power-on timeout.
    pin_low_por_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        q.phase == sysint_pkg::PH_POR
        |-> reset_pin_low_out)
        else $error("Reset pin not low in timeout.");

    // The pin is released once the clocks run.
    pin_release_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        running
        |-> !reset_pin_low_out)
        else $error("Reset pin held low while running.");

    // No peripheral clock outside the run phase.
    clk_gated_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        q.phase != sysint_pkg::PH_RUN
        |-> !periph_clk_en_out)
        else $error("Clock active before timeout.");

    // The processor clock is held off through the timeout.
    por_cpu_off_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        q.phase == sysint_pkg::PH_POR
        |-> !cpu_clk_en_out)
        else $error("CPU clock active in timeout.");

    // The terminal count of the power-on timeout starts the clocks.
    por_end_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        q.phase == sysint_pkg::PH_POR && q.count == term &&
        !cause_in.power_on && !cause_in.low_voltage
        |=> running)
        else $error("Timeout did not end at terminal count.");

    // A tick is followed by three quiet cycles.
    bus_div_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        bus_tick_out && running && $stable(running)
        |=> !bus_tick_out ##1 !bus_tick_out ##1 !bus_tick_out)
        else $error("Bus tick not divided by four.");

    // The short delay ends thirty-two cycles after stop exit.
    short_stop_a: assert property (
        @(posedge mclk_in) disable iff
        (!rst_n_in || cause_in.power_on || cause_in.low_voltage)
        $rose(q.phase == sysint_pkg::PH_DELAY) &&
        q.ctrl[sysint_pkg::BIT_SHORT_STOP] && !wr_in
        |-> ##32 running)
        else $error("Short stop delay wrong.");

    // The delay counter starts from zero on every stop exit.
    count_clear_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        $rose(q.phase == sysint_pkg::PH_DELAY)
        |-> q.count == 13'h0000)
        else $error("Stop delay counter not cleared.");

    // Clocks stay off in stop and in the stop-exit delay.
    delay_gated_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        q.phase == sysint_pkg::PH_DELAY || q.phase == sysint_pkg::PH_STOP
        |-> !cpu_clk_en_out && !periph_clk_en_out)
        else $error("Clock active in stop delay.");

    // The stop delay releases the clocks at its terminal count.
    stop_end_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        q.phase == sysint_pkg::PH_DELAY && q.count == term &&
        !cause_in.power_on && !cause_in.low_voltage
        |=> running)
        else $error("Stop delay did not end.");

    // A read outside break clears the source flags.
    rsr_read_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        rd_in && addr_in == sysint_pkg::ADDR_RESET_SOURCE &&
        !break_in && !(|causes) && !cause_in.power_on
        |=> q.reset_source_status == 8'h00)
        else $error("Source flags not cleared on read.");

    // A power-on cause leaves no flag standing.
    por_clear_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        cause_in.power_on
        |=> q.reset_source_status == 8'h00)
        else $error("Source flags kept over power-on.");

    // In break with clearing disabled the flags must survive a read.
    break_hold_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        rd_in && addr_in == sysint_pkg::ADDR_RESET_SOURCE &&
        break_in && !q.break_clear_enable && !(|causes) && !cause_in.power_on
        |=> $stable(q.reset_source_status))
        else $error("Flags cleared in break.");

    // In break with clearing enabled a read still clears.
    break_clear_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        rd_in && addr_in == sysint_pkg::ADDR_RESET_SOURCE &&
        break_in && q.break_clear_enable && !(|causes) && !cause_in.power_on
        |=> q.reset_source_status == 8'h00)
        else $error("Flags kept in break with clearing enabled.");

    // A pin reset shows in the pin flag.
    pin_flag_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        cause_in.pin && !cause_in.power_on && !cause_in.low_voltage
        |=> q.reset_source_status[sysint_pkg::BIT_PIN])
        else $error("Pin flag not set.");

    // A watchdog reset shows in the watchdog flag.
    dog_flag_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        cause_in.watchdog && !cause_in.power_on && !cause_in.low_voltage
        |=> q.reset_source_status[sysint_pkg::BIT_WATCHDOG])
        else $error("Watchdog flag not set.");

    // An illegal opcode reset shows in its flag.
    illop_flag_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        cause_in.illegal_op && !cause_in.power_on && !cause_in.low_voltage
        |=> q.reset_source_status[sysint_pkg::BIT_ILLEGAL_OP])
        else $error("Illegal opcode flag not set.");

    // Data accesses to bad addresses must not flag.
    iaddr_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        cause_in.illegal_addr && !illegal_is_fetch_in &&
        !cause_in.power_on
        |=> !q.reset_source_status[sysint_pkg::BIT_ILLEGAL_ADDR])
        else $error("Data access flagged address.");

    // A monitor entry reset shows in its flag.
    mon_flag_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        cause_in.monitor && !cause_in.power_on && !cause_in.low_voltage
        |=> q.reset_source_status[sysint_pkg::BIT_MONITOR])
        else $error("Monitor flag not set.");

    // A low-voltage reset shows in its flag.
    lv_flag_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        cause_in.low_voltage && !cause_in.power_on
        |=> q.reset_source_status[sysint_pkg::BIT_LOW_VOLTAGE])
        else $error("Low voltage flag not set.");

    // The oscillator runs outside stop while it is enabled.
    osc_run_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        q.ctrl[sysint_pkg::BIT_OSC_EN] && q.phase != sysint_pkg::PH_STOP
        |-> oscillator_enable_out)
        else $error("Oscillator off outside stop.");

    // The disable bit turns the oscillator off in stop.
    osc_off_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        q.phase == sysint_pkg::PH_STOP && q.ctrl[sysint_pkg::BIT_INTERNAL_OSC_CLOCK_DIS]
        |-> !oscillator_enable_out)
        else $error("Oscillator on in stop.");

    // Wait stops the processor only; peripherals keep their clock.
    wait_cpu_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        wait_req_in && running
        |-> !cpu_clk_en_out && periph_clk_en_out)
        else $error("Wait clock gating wrong.");

    // Read data stand only in the cycle after a read strobe.
    rdata_idle_a: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        !rd_in
        |=> rdata_out == 8'h00)
        else $error("Read data outside read cycle.");

endmodule // sim_clock_reset_status

/* File: sim/clock_consumer_model.sv */
// Model of the peripheral clock consumers fed by the bus tick.
`timescale 1ns/10ps
module clock_consumer_model (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Gated clocks from the block.
    input wire logic bus_tick_in,
    input wire logic periph_clk_en_in,
    // Faults seen by the consumers.
    output int errors_out
);
    int gap_q;
    // Ticks come every fourth clock; the gap restarts while gated off,
    // so the first tick after a restart is never judged.
    always @(posedge mclk_in) begin
        if (rst_n_in !== 1'b1 || periph_clk_en_in !== 1'b1) begin
            gap_q <= 0;
        end else if (bus_tick_in === 1'b1) begin
            gap_q <= 1;
            if (gap_q != 0 && gap_q != 4) errors_out <= errors_out + 1;
        end else if (gap_q != 0) begin
            gap_q <= gap_q + 1;
        end
    end
    initial errors_out = 0;
endmodule // clock_consumer_model

/* File: sim/sim_clock_reset_status_test.sv */
// Self-checking bench for the clock, reset and status block.
`timescale 1ns/10ps
module sim_clock_reset_status_test;
    // ---------------------------------------------------------------
    // Signals and table
    // ---------------------------------------------------------------
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    sysint_pkg::reset_cause_type cause = '0;
    logic fetch = 1'b0, stop_req = 1'b0, wait_req = 1'b0;
    logic wake = 1'b0, brk = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, v;
    logic tick, cpu_en, per_en, pin_low, osc_en, irq, irq0;
    int num_errors = 0, n_checks = 0, model_errors, n;
    typedef struct packed {
        logic [6:0] cause;
        logic fetch;
        logic [7:0] flags;
    } row_type;
    row_type rows [7] = '{
        '{7'h10, 1'b0, 8'h40},
        '{7'h08, 1'b0, 8'h20},
        '{7'h04, 1'b0, 8'h10},
        '{7'h02, 1'b1, 8'h08},
        '{7'h02, 1'b0, 8'h00},
        '{7'h01, 1'b0, 8'h04},
        '{7'h20, 1'b0, 8'h02}};

    // The raw oscillator clock reaches the block undivided.
    initial begin
        forever #(sysint_pkg::CLK_PERIOD_NS / 2) mclk_in = ~mclk_in;
    end

    sim_clock_reset_status dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .cause_in(cause), .illegal_is_fetch_in(fetch),
        .stop_req_in(stop_req), .wait_req_in(wait_req), .wake_in(wake),
        .break_in(brk), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdata), .bus_tick_out(tick),
        .cpu_clk_en_out(cpu_en), .periph_clk_en_out(per_en),
        .reset_pin_low_out(pin_low), .oscillator_enable_out(osc_en),
        .irq_out(irq));
    clock_consumer_model model (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .bus_tick_in(tick), .periph_clk_en_in(per_en),
        .errors_out(model_errors));

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_in);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_in);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic wait_run(output int c);
        c = 0;
        while (per_en !== 1'b1 && c < 5000) begin
            @(posedge mclk_in);
            #1;
            c++;
        end
    endtask
    task automatic strobe(input bit to_wake);
        @(posedge mclk_in);
        if (to_wake) begin
            wake <= 1'b1;
        end else begin
            stop_req <= 1'b1;
        end
        @(posedge mclk_in);
        wake <= 1'b0;
        stop_req <= 1'b0;
        repeat (3) @(posedge mclk_in);
        #1;
    endtask
    task automatic wrap_up();
        num_errors += model_errors;
        $display("Checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        repeat (16) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        #1;
        chk("pin low", 1'b1, pin_low);
        chk("cpu en", 1'b0, cpu_en);
        wait_run(n);
        chk("por wait", 1'b1, n >= 4096 && n <= 4097);
        chk("pin low", 1'b0, pin_low);
        rd_reg(sysint_pkg::ADDR_CONTROL, v);
        chk("ctrl", sysint_pkg::CONTROL_RESET, v);
        rd_reg(sysint_pkg::ADDR_IRQ_MASK, v);
        chk("mask", 8'h00, v);
        rd_reg(sysint_pkg::ADDR_RESET_SOURCE, v);
        chk("source", 8'h00, v);
        $display("Test power on done");
        // Every reset cause except power-on in turn, each read twice.
        foreach (rows[i]) begin
            @(posedge mclk_in);
            cause <= rows[i].cause;
            fetch <= rows[i].fetch;
            @(posedge mclk_in);
            cause <= '0;
            if (rows[i].cause[5]) begin
                #1;
                chk("pin low", 1'b1, pin_low);
                wait_run(n);
                chk("lv wait", 1'b1, n >= 4094 && n <= 4097);
            end
            rd_reg(sysint_pkg::ADDR_RESET_SOURCE, v);
            chk("flags", rows[i].flags, v);
            rd_reg(sysint_pkg::ADDR_RESET_SOURCE, v);
            chk("flags reread", 8'h00, v);
        end
        $display("Test sources done");
        n = 0;
        repeat (40) begin
            @(posedge mclk_in);
            #1;
            if (tick === 1'b1) n++;
        end
        chk("ticks", 16'd10, 16'(n));
        @(posedge mclk_in);
        wait_req <= 1'b1;
        repeat (3) @(posedge mclk_in);
        #1;
        chk("wait cpu", 1'b0, cpu_en);
        chk("wait periph", 1'b1, per_en);
        wait_req <= 1'b0;
        rd_reg(sysint_pkg::ADDR_IRQ_STATUS, v);
        chk("irq status", 8'h05, v);
        irq0 = irq;
        wr_reg(sysint_pkg::ADDR_IRQ_MASK, 8'h07);
        #1;
        chk("mask effect", 1'b1, irq0 !== irq);
        wr_reg(sysint_pkg::ADDR_IRQ_STATUS, 8'h07);
        rd_reg(sysint_pkg::ADDR_IRQ_STATUS, v);
        chk("irq clear", 8'h00, v);
        chk("irq low", 1'b0, irq);
        $display("Test wait and irq done");
        // Break state protects the flags unless clearing is enabled.
        @(posedge mclk_in);
        brk <= 1'b1;
        cause <= 7'h10;
        @(posedge mclk_in);
        cause <= '0;
        repeat (2) rd_reg(sysint_pkg::ADDR_RESET_SOURCE, v);
        chk("break keep", 8'h40, v);
        wr_reg(sysint_pkg::ADDR_BREAK_FLAG, 8'h80);
        rd_reg(sysint_pkg::ADDR_BREAK_FLAG, v);
        chk("break_clear_enable", 8'h80, v);
        repeat (2) rd_reg(sysint_pkg::ADDR_RESET_SOURCE, v);
        chk("break clear", 8'h00, v);
        brk <= 1'b0;
        wr_reg(4'h0, 8'hff);
        rd_reg(4'h0, v);
        chk("unmapped", 8'h00, v);
        $display("Test break done");
        // A power-on cause restarts the timeout and clears the flags.
        @(posedge mclk_in);
        cause <= 7'h50;
        @(posedge mclk_in);
        cause <= '0;
        #1;
        chk("por pin", 1'b1, pin_low);
        wait_run(n);
        chk("por again", 1'b1, n >= 4094 && n <= 4097);
        rd_reg(sysint_pkg::ADDR_RESET_SOURCE, v);
        chk("por flags", 8'h00, v);
        rd_reg(sysint_pkg::ADDR_STATE, v);
        chk("phase", 8'h01, v);
        $display("Test power on cause done");
        // Short then long stop delay, clock disable in the long one.
        for (int k = 0; k < 2; k++) begin
            wr_reg(sysint_pkg::ADDR_CONTROL, k == 0 ? 8'h05 : 8'h06);
            strobe(1'b0);
            chk("stop periph", 1'b0, per_en);
            chk("stop osc", k == 0, osc_en);
            strobe(1'b1);
            wait_run(n);
            n += 4;
            chk("stop wait", 1'b1, k == 0 ? (n >= 31 && n <= 33)
                : (n >= 4095 && n <= 4097));
        end
        chk("osc on", 1'b1, osc_en);
        wr_reg(sysint_pkg::ADDR_CONTROL, 8'h00);
        #1;
        chk("osc off", 1'b0, osc_en);
        $display("Test stop done");
        wrap_up();
    end

    // Cut a hang short well past the longest expected run.
    initial begin
        #(40000 * sysint_pkg::CLK_PERIOD_NS);
        num_errors++;
        wrap_up();
    end
endmodule // sim_clock_reset_status_test
